/* File: common/msd_map.svh */
// Purpose: address map constants for the memory space decoder
// Assumes: byte addresses; 8-bit internal, 16-bit program and external spaces
// Notes:   definitions only
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH
`define MSD_IDATA_HALF      8'h80
`define MSD_BANK_TOP        8'h1F
`define MSD_BITAREA_LO      8'h20
`define MSD_BITAREA_HI      8'h2F
`define MSD_FLASH_TOP       16'h3DFF
`define MSD_XWIN_MASK       16'h07FF
`define MSD_EXTERNAL_DATA_RAM_TOP        16'h03FF
`define MSD_FIFO_BASE       16'h0400
`define MSD_EP3_FIFO_BYTES  16'h0200
`define MSD_EP3_FIFO_BASE   16'h0600
`define MSD_BANK_SHIFT      3
`endif

/* File: common/msd_pkg.sv */
// Purpose: types for the memory space decoder
// Assumes: included map header for constants
// Notes:   access kinds and targets
package msd_pkg;
	typedef enum logic [2:0] {
		MSD_ACC_NONE     = 3'h0,
		MSD_ACC_DIRECT   = 3'h1,
		MSD_ACC_INDIRECT = 3'h3,
		MSD_ACC_CODE     = 3'h2,
		MSD_ACC_XMOVE    = 3'h6
	} msd_access_t;
	typedef enum logic [2:0] {
		MSD_TGT_NONE     = 3'h0,
		MSD_TGT_IRAM     = 3'h1,
		MSD_TGT_SFR      = 3'h3,
		MSD_TGT_FLASH    = 3'h2,
		MSD_TGT_EXTERNAL_DATA_RAM     = 3'h6,
		MSD_TGT_FIFO     = 3'h7,
		MSD_TGT_RESERVED = 3'h5
	} msd_target_t;
endpackage

/* File: hdl/msd_sel_reg.sv */
// Purpose: registered copy of a decode word
// Assumes: one clock, asynchronous active low reset from synchronised copy
// Notes:   keeps every top output straight from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module msd_sel_reg #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// data
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	// plain pipeline stage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q_out <= '0;
		end else begin
			q_out <= d_in;
		end
	end
endmodule // msd_sel_reg
`default_nettype wire

/* File: hdl/msd_decoder.sv */
// Purpose: steer each core access to one memory target
// Assumes: core drives address and access kind on core_clk_in
// Notes:   decode is combinational, outputs registered once
//          every result leaves through its own register stage, so the
//          core sees the decode one cycle after it presents an access
//          undefined access kinds select no target and clear the flags
`timescale 1ns/1ps
`default_nettype none
`include "msd_map.svh"
module msd_decoder
	import msd_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// core access
	input  wire logic [15:0] addr_in,
	input  wire logic [2:0]  access_in,
	input  wire logic        bit_access_in,
	// decode results
	output logic [2:0]       target_out,
	output logic [15:0]      local_addr_out,
	output logic [1:0]       reg_bank_out,
	output logic             bank_hit_out,
	output logic             bit_area_out,
	output logic             ep3_fifo_out
);
	logic        rst_meta_reg;
	logic        rst_sync_reg;
	wire  [7:0]  iaddr = addr_in[7:0];
	wire         upper_half;
	wire  [15:0] xaddr;
	wire         is_direct;
	wire         is_indirect;
	wire         is_code;
	wire         is_xmove;
	msd_target_t target_next;
	wire  [15:0] local_next;
	wire  [1:0]  bank_next;
	wire         bank_hit_next;
	wire         bit_area_next;
	wire         ep3_next;
	// shared range tests
	wire         is_internal;
	wire         in_bank;
	wire         in_bit_area;
	wire         x_in_ram;
	wire         x_in_ep3;
	wire  [15:0] ep3_top;
	// rebased offsets
	wire  [15:0] local_internal;
	wire  [15:0] local_external;

	// field widths of the registered decode results
	localparam int TGT_W   = 3;
	localparam int LOCAL_W = 16;
	localparam int BANK_W  = 2;
	localparam int FLAG_W  = 1;

	// reset release through two flip-flops
	// the reset pin is asynchronous; releasing it straight into the output
	// stage could let some flops leave reset one edge before others, so the
	// rest of the block only ever sees the synchronised copy
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// access kind decode
	// each access kind is a single code; any code outside the list
	// leaves all four strobes low and falls through to no target
	// the external address is folded onto the 2K window here, once
	assign is_direct   = (access_in == MSD_ACC_DIRECT);
	assign is_indirect = (access_in == MSD_ACC_INDIRECT);
	assign is_code     = (access_in == MSD_ACC_CODE);
	assign is_xmove    = (access_in == MSD_ACC_XMOVE);
	assign upper_half  = (iaddr >= `MSD_IDATA_HALF);
	assign xaddr       = addr_in & `MSD_XWIN_MASK;

	// range tests shared by the target, offset and flag logic
	// internal tests look only at the low byte of the address;
	// external tests look only at the folded window address, so
	// every alias of a location decodes exactly like the original
	assign is_internal    = is_direct || is_indirect;
	assign in_bank        = (iaddr <= `MSD_BANK_TOP);
	assign in_bit_area    = (iaddr >= `MSD_BITAREA_LO)
		&& (iaddr <= `MSD_BITAREA_HI);
	assign x_in_ram       = (xaddr <= `MSD_EXTERNAL_DATA_RAM_TOP);
	assign ep3_top        = `MSD_EP3_FIFO_BASE + `MSD_EP3_FIFO_BYTES;
	assign x_in_ep3       = (xaddr >= `MSD_EP3_FIFO_BASE) && (xaddr < ep3_top);
	assign local_internal = {8'h00, iaddr};
	assign local_external = x_in_ram ? xaddr : (xaddr - `MSD_FIFO_BASE);

	// one target per access
	// the upper internal half is split by access kind alone: direct goes
	// to the special function register space, indirect to upper RAM
	// the default keeps every path assigned and covers unknown kinds
	always_comb begin
		target_next = MSD_TGT_NONE;
		if (is_direct || is_indirect) begin
			if (!upper_half) begin
				target_next = MSD_TGT_IRAM;
			end else if (is_indirect) begin
				target_next = MSD_TGT_IRAM;
			end else begin
				target_next = MSD_TGT_SFR;
			end
		end else if (is_code) begin
			target_next = (addr_in <= `MSD_FLASH_TOP) ? MSD_TGT_FLASH
				: MSD_TGT_RESERVED;
		end else if (is_xmove) begin
			target_next = (xaddr <= `MSD_EXTERNAL_DATA_RAM_TOP) ? MSD_TGT_EXTERNAL_DATA_RAM
				: MSD_TGT_FIFO;
		end
	end

	// offsets within the chosen target
	// internal spaces keep the byte address; the external window is
	// rebased so a FIFO access starts at zero inside the FIFO region
	assign local_next = is_internal ? local_internal
		: is_xmove ? local_external
		: is_code ? addr_in : 16'h0000;

	// register bank number from the two bits above the bank offset
	assign bank_hit_next = is_internal && in_bank;
	assign bank_next = bank_hit_next ? iaddr[`MSD_BANK_SHIFT+1:`MSD_BANK_SHIFT]
		: 2'b00;

	// bit area flag: internal byte accesses inside the area, and every internal bit access,
	// since single bits are only reached through that area
	assign bit_area_next = is_internal && (in_bit_area || bit_access_in);

	// endpoint three owns the top half of the FIFO region
	assign ep3_next = is_xmove && x_in_ep3;

	// output stage
	// each decode result has a register of its own, so no packing
	// order can shift one field into another; all of them are cleared
	// by the synchronised reset and load on every edge after it
	// the outputs therefore come straight from flip-flops

	// target code register
	// holds the selected target for one cycle per sampled access
	msd_sel_reg #(
		.WIDTH (TGT_W)
	) u_target_reg (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_sync_reg),
		.d_in     (target_next),
		.q_out    (target_out)
	);

	// offset register
	// offset inside the selected target, zero for no target
	msd_sel_reg #(
		.WIDTH (LOCAL_W)
	) u_local_reg (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_sync_reg),
		.d_in     (local_next),
		.q_out    (local_addr_out)
	);

	// bank number register
	// zero whenever the access is outside the working registers
	msd_sel_reg #(
		.WIDTH (BANK_W)
	) u_bank_reg (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_sync_reg),
		.d_in     (bank_next),
		.q_out    (reg_bank_out)
	);

	// bank hit flag register
	// high for internal accesses to the working registers
	msd_sel_reg #(
		.WIDTH (FLAG_W)
	) u_bank_hit_reg (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_sync_reg),
		.d_in     (bank_hit_next),
		.q_out    (bank_hit_out)
	);

	// bit area flag register
	// high for internal accesses that land in the bit area
	msd_sel_reg #(
		.WIDTH (FLAG_W)
	) u_bit_area_reg (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_sync_reg),
		.d_in     (bit_area_next),
		.q_out    (bit_area_out)
	);

	// endpoint three flag register
	// high for external moves into the endpoint three FIFO
	msd_sel_reg #(
		.WIDTH (FLAG_W)
	) u_ep3_reg (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_sync_reg),
		.d_in     (ep3_next),
		.q_out    (ep3_fifo_out)
	);

	// no state is kept beyond the reset synchroniser and the output
	// stage; the decode never depends on an earlier access
endmodule // msd_decoder
`default_nettype wire

/* File: verif/msd_decoder_chk.sv */
// Purpose: decode checks on the decoder ports
// Assumes: one clock, outputs one cycle behind inputs
// Notes: idle for three edges after reset release
`timescale 1ns/1ps
`default_nettype none
module msd_chk (
	input wire logic        core_clk_in, resetn_in, bit_access_in,
	input wire logic        bank_hit_out, bit_area_out, ep3_fifo_out,
	input wire logic [15:0] addr_in, local_addr_out,
	input wire logic [2:0]  access_in, target_out,
	input wire logic [1:0]  reg_bank_out
);
	logic [1:0] cnt_reg;
	// ready once the reset synchroniser has let go
	wire logic rdy = cnt_reg == 2'h3;
	wire logic inr = access_in == 3'h1 || access_in == 3'h3;
	// count edges since reset release
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			cnt_reg <= 2'h0;
		else if (!rdy)
			cnt_reg <= cnt_reg + 2'h1;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	a_ind_upper: assert property (rdy && access_in == 3'h3 && addr_in[7]
		|=> target_out == 3'h1) else $error("indirect upper");
	a_dir_upper: assert property (rdy && access_in == 3'h1 && addr_in[7]
		|=> target_out == 3'h3) else $error("direct upper");
	a_low_ram: assert property (rdy && inr && !addr_in[7] |=> target_out == 3'h1)
		else $error("lower ram");
	a_bank_num: assert property (rdy && inr && addr_in[7:5] == 3'h0
		|=> bank_hit_out && reg_bank_out == $past(addr_in[4:3])) else $error("bank");
	a_code_map: assert property (rdy && access_in == 3'h2
		|=> target_out == ($past(addr_in) > 16'h3DFF ? 3'h5 : 3'h2)) else $error("code");
	a_ext_map: assert property (rdy && access_in == 3'h6
		|=> target_out == ($past(addr_in[10]) ? 3'h7 : 3'h6)) else $error("ext");
	a_ext_alias: assert property (rdy && access_in == 3'h6
		|=> local_addr_out == {6'h00, $past(addr_in[9:0])}) else $error("alias");
	a_bit_area: assert property (rdy && inr
		|=> bit_area_out == ($past(addr_in[7:4]) == 4'h2 || $past(bit_access_in)))
		else $error("bit area");
	a_ep3_hit: assert property (rdy && access_in == 3'h6
		|=> ep3_fifo_out == ($past(addr_in[10:9]) == 2'h3)) else $error("ep3");
	a_one_tgt: assert property (rdy && !(inr || access_in == 3'h2 || access_in == 3'h6)
		|=> target_out == 3'h0) else $error("unknown kind");
	c_sfr: cover property (rdy && access_in == 3'h1 && addr_in[7]);
	c_fifo: cover property (rdy && access_in == 3'h6 && addr_in[10]);
	c_resv: cover property (rdy && access_in == 3'h2 && addr_in[15]);
endmodule // msd_chk
bind msd_decoder msd_chk msd_chk_inst (.*);
`default_nettype wire

/* File: verif/msd_core_model.sv */
// Purpose: core side issuing accesses
// Assumes: called at the falling edge
// Notes: holds each access as a level
`timescale 1ns/1ps
`default_nettype none
module msd_core_model (
	output logic [15:0] addr_out,
	output logic [2:0]  access_out,
	output logic        bit_out
);
	// idle until the first access
	initial begin
		addr_out = 16'h0000;
		access_out = 3'h0;
		bit_out = 1'b0;
	end
	// present one access to the decoder
	task issue(input logic [2:0] kd, input logic [15:0] ad);
		access_out = kd;
		addr_out = ad;
		bit_out = ad[0];
	endtask
endmodule // msd_core_model
`default_nettype wire

/* File: verif/msd_decoder_test.sv */
// Purpose: self-checking bench for the decoder
// Assumes: inputs change at the falling edge
// Notes: outputs checked one cycle later
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_test;
	logic clk = 0, rst_n = 0, b, bh, ep, ba;
	logic [15:0] a, la;
	logic [2:0] k, tg;
	logic [1:0] rb;
	int miscompares = 0, tests_run = 0;
	initial forever #5 clk = ~clk;
	msd_core_model msd_core_model_inst (.addr_out(a), .access_out(k), .bit_out(b));
	msd_decoder msd_decoder_inst (.core_clk_in(clk), .resetn_in(rst_n), .addr_in(a),
		.access_in(k), .bit_access_in(b), .target_out(tg), .local_addr_out(la),
		.reg_bank_out(rb), .bank_hit_out(bh), .bit_area_out(ba), .ep3_fifo_out(ep));
	task chk(input logic [15:0] g, e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task go(input logic [2:0] kd, input logic [15:0] ad);
		msd_core_model_inst.issue(kd, ad);
		@(negedge clk);
	endtask
	task test_internal;
		logic [15:0] ad;
		logic [2:0]  kd;
		for (int i = 0; i < 16; i++) begin
			ad = {8'hA5, i[3:0], i[3:0]};
			kd = i[0] ? 3'h3 : 3'h1;
			go(kd, ad);
			chk(tg, ad[7] ? (kd == 3'h1 ? 3'h3 : 3'h1) : 3'h1);
			if (ad[7:5] == 3'h0) chk({bh, rb}, {1'b1, ad[4:3]});
			chk(ba, ad[7:4] == 4'h2 || ad[0]);
		end
		$display("internal done");
	endtask
	task test_code_ext;
		logic [15:0] ad;
		for (int i = 0; i < 32; i++) begin
			ad = {i[4:0], i[1:0], 9'h0C3};
			go(3'h2, ad);
			chk(tg, ad > 16'h3DFF ? 3'h5 : 3'h2);
			go(3'h6, ad);
			chk(tg, ad[10] ? 3'h7 : 3'h6);
			chk(la, {6'h00, ad[9:0]});
			chk(ep, ad[10:9] == 2'h3);
		end
		go(3'h2, 16'h3DFF);
		chk(tg, 3'h2);
		go(3'h2, 16'h3E00);
		chk(tg, 3'h5);
		for (int i = 0; i < 8; i++) begin
			go(i[2:0], 16'h0480);
			if (i == 0 || i == 4 || i == 5 || i == 7) chk(tg, 3'h0);
		end
		$display("code and external done");
	endtask
	task summarize;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		test_internal();
		test_code_ext();
		summarize();
	end
endmodule // msd_decoder_test
`default_nettype wire
